// *** design/dss_dev_end.sv ***
// device end: serial command port of the dual channel switch controller
//
// What this block does
// - 16-bit words, MSB first, both lines
// - no transfer accepted while reset held
// - master toggles D15 within watchdog time
// - D14 gives even parity; checked on last word
// - decode bank, address and data fields
// - wrong length or parity: transfer discarded
// - shift out and sample on same edges
// - first word from previously pointed register
// - validate and latch on chip select rise
// - after latch: output off, status refreshed
// - input echoed out one word later
// - second word out is first word in
// - master holds select low until target
// - thirteen input and thirteen output registers
// - prewarning flag set in normal mode only, channel stays on
// - flag clears on fault read when cool
// - output bits zero, one show channel state
// - bank bit zero channel 0, one channel 1
// - pointer low bits choose next output register
`timescale 1ns/1ps
`default_nettype none
module dss_dev_end
    import dss_pkg::*;
(
    input  wire logic                  ref_clk_in,
    input  wire logic                  sys_rst_in,
    input  wire logic                  clk_en_in,
    dss_spi_if.dev                     link,
    input  wire logic [1:0]            ch_on_in,
    input  wire logic                  temp_high_in,
    input  wire logic                  normal_mode_in,
    input  wire logic [6:0]            status_misc_in,
    input  wire logic [11:0]           fault_bits_in,
    input  wire logic [8:0]            diag_in,
    output logic      [1:0][7:0][9:0]  input_regs_out,
    output logic                       latch_pulse_out,
    output logic                       temp_prewarning_flag_out
);
    // =====================================================================
    // state of both domains
    typedef struct packed {
        dss_word_t   shift;
        dss_word_t   last_word;
        logic [3:0]  bit_cnt;
        logic [7:0]  word_cnt;
    } dss_link_state_t;

    typedef struct packed {
        logic                 cs_prev;
        logic [3:0]           snap_bits;
        logic [7:0]           snap_words;
        logic [1:0][7:0][9:0] regs;
        logic                 ptr_bank;
        logic [2:0]           ptr;
        logic                 watchdog_toggle_bit;
        logic                 parity_fault;
        logic                 temp_prewarning_flag;
        dss_word_t            tx_word;
        logic                 latch_pulse;
    } dss_ref_state_t;

    localparam dss_ref_state_t REF_RESET = '{cs_prev: CS_IDLE_LEVEL, default: '0};

    dss_link_state_t lk;
    dss_link_state_t next_lk;
    dss_ref_state_t  r;
    dss_ref_state_t  next_r;
    logic            fresh;

    // =====================================================================
    // pin synchronisers
    logic [33:0] pins_sync;
    logic        s_cs_n;
    logic        s_rst_n;
    logic [1:0]  s_ch_on;
    logic        s_temp_high;
    logic        s_normal;
    logic [6:0]  s_misc;
    logic [11:0] s_faults;
    logic [8:0]  s_diag;

    dss_sync #(
        .WIDTH (34)
    ) u_pin_sync (
        .ref_clk_in (ref_clk_in),
        .sys_rst_in (sys_rst_in),
        .clk_en_in  (clk_en_in),
        .async_in   ({link.chip_select_n, link.reset_input_n, ch_on_in, temp_high_in,
                      normal_mode_in, status_misc_in, fault_bits_in, diag_in}),
        .sync_out   (pins_sync)
    );

    assign {s_cs_n, s_rst_n, s_ch_on, s_temp_high, s_normal, s_misc, s_faults, s_diag} = pins_sync;

    // =====================================================================
    // link clock domain: shifter and word counters
    // counters run free; the reference side compares them with a snapshot
    // taken while the select is high, when the link clock stands still
    always_comb begin
        dss_word_t shifted;
        shifted = '0;
        next_lk = lk;
        shifted = {(fresh ? r.tx_word[WORD_BITS-2:0] : lk.shift[WORD_BITS-2:0]), link.serial_in};
        next_lk.shift   = shifted;
        next_lk.bit_cnt = lk.bit_cnt + 4'h1;
        if (lk.bit_cnt == 4'hF) begin
            next_lk.last_word = shifted;
            next_lk.word_cnt  = lk.word_cnt + 8'h01;
        end
    end

    always_ff @(posedge link.link_clk or negedge link.reset_input_n) begin
        if (!link.reset_input_n) begin
            lk <= '0;
        end else begin
            lk <= next_lk;
        end
    end

    // first edge of a frame takes the prepared word; select high rearms it
    always_ff @(posedge link.link_clk or posedge link.chip_select_n) begin
        if (link.chip_select_n) begin
            fresh <= 1'b1;
        end else begin
            fresh <= 1'b0;
        end
    end

    // msb leads before the first edge; after sixteen edges the shifter
    // holds the first input word, which gives the one-word chain delay
    assign link.serial_out      = fresh ? r.tx_word[WDOG_POS] : lk.shift[WORD_BITS-1];
    assign link.serial_out_oe_n = link.chip_select_n;

    // =====================================================================
    // output word for the next transfer
    function automatic dss_word_t dss_so_word(
        input dss_ref_state_t s,
        input logic           nm,
        input logic [8:0]     status_bits,
        input logic [11:0]    faults,
        input logic [8:0]     diag
    );
        logic [8:0] data;
        logic       soa3;
        data = '0;
        soa3 = s.ptr_bank;
        case (s.ptr)
            SEL_STATUS: begin
                data = status_bits;
                soa3 = 1'b0;
            end
            SEL_FAULT: begin
                data = {s.temp_prewarning_flag, 2'b00, (s.ptr_bank ? faults[11:6] : faults[5:0])};
            end
            SEL_DUTY: begin
                data = s.regs[s.ptr_bank][ADDR_DUTY][8:0];
            end
            SEL_CHAN: begin
                data = s.regs[s.ptr_bank][ADDR_CHAN_CFG][8:0];
            end
            SEL_OC: begin
                data = s.regs[s.ptr_bank][ADDR_OC_CFG][8:0];
            end
            SEL_RETRY: begin
                data = s.regs[s.ptr_bank][ADDR_RETRY_CFG][8:0];
            end
            SEL_GLOBAL: begin
                data = s.regs[0][ADDR_GLOBAL_CFG][8:0];
                soa3 = 1'b0;
            end
            default: begin
                data = diag;
                soa3 = 1'b0;
            end
        endcase
        return {s.watchdog_toggle_bit, s.parity_fault, soa3, s.ptr, nm, data};
    endfunction : dss_so_word

    // =====================================================================
    // reference domain: validation, latching and status
    dss_word_t  rx_word;
    logic [2:0] addr;
    logic       bank;
    logic       idle;
    logic       rise;
    logic       moved;
    logic       len_ok;
    logic       par_ok;
    logic       cal_ok;
    logic       fault_read;
    dss_field_t wmask;

    always_comb begin
        next_r             = r;
        next_r.latch_pulse = 1'b0;
        // both synchronisers warm up together after a reset, so a select
        // output still at its reset low must not arm a false rise
        next_r.cs_prev     = s_cs_n || !s_rst_n;
        rx_word = lk.last_word;
        addr    = rx_word[ADDR_MSB:ADDR_LSB];
        bank    = (addr == ADDR_GLOBAL_CFG) ? 1'b0 : rx_word[BANK_POS];
        idle    = s_cs_n && r.cs_prev;
        rise    = s_cs_n && !r.cs_prev;
        moved   = (lk.word_cnt != r.snap_words);
        len_ok  = moved && (lk.bit_cnt == r.snap_bits);
        par_ok  = !dss_odd_ones(rx_word);
        cal_ok  = (addr != ADDR_CAL) || (rx_word[DATA_BITS-1:0] == CAL_PATTERN);
        if (addr == ADDR_STATUS_PTR) begin
            wmask = MASK_STATUS_PTR;
        end else if (addr == ADDR_RETRY_CFG) begin
            wmask = MASK_RETRY;
        end else begin
            wmask = MASK_CFG;
        end
        fault_read = rise && s_rst_n && moved && (r.ptr == SEL_FAULT);
        // a new hot reading wins over a clearing read in the same cycle
        next_r.temp_prewarning_flag = (s_normal && s_temp_high)
                   || (r.temp_prewarning_flag && !(fault_read && !s_temp_high));
        if (idle) begin
            next_r.snap_bits  = lk.bit_cnt;
            next_r.snap_words = lk.word_cnt;
            next_r.tx_word    = dss_so_word(r, s_normal, {s_misc, s_ch_on}, s_faults, s_diag);
        end
        if (rise && s_rst_n) begin
            if (moved) begin
                next_r.parity_fault = !par_ok;
                next_r.watchdog_toggle_bit         = rx_word[WDOG_POS];
            end
            if (len_ok && par_ok && cal_ok) begin
                next_r.regs[bank][addr] = rx_word[DATA_BITS-1:0] & wmask;
                next_r.latch_pulse      = 1'b1;
                if (addr == ADDR_STATUS_PTR) begin
                    next_r.ptr_bank = rx_word[BANK_POS];
                    next_r.ptr      = rx_word[2:0];
                end
            end
        end
        if (!s_rst_n) begin
            for (int b = 0; b < 2; b++) begin
                for (int a = 0; a < 8; a++) begin
                    next_r.regs[b][a] = FIELD_RESET;
                end
            end
            next_r.ptr_bank = 1'b0;
            next_r.ptr      = SEL_STATUS;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            r <= REF_RESET;
        end else if (clk_en_in) begin
            r <= next_r;
        end
    end

    // =====================================================================
    // user side
    assign input_regs_out           = r.regs;
    assign latch_pulse_out          = r.latch_pulse;
    assign temp_prewarning_flag_out = r.temp_prewarning_flag;
endmodule : dss_dev_end
`default_nettype wire

// *** design/dss_host_end.sv ***
// master end: issues command words and collects status words
`timescale 1ns/1ps
`default_nettype none
module dss_host_end
    import dss_pkg::*;
(
    input  wire logic        ref_clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        clk_en_in,
    dss_spi_if.host          link,
    input  wire logic        cmd_valid_in,
    input  wire logic [13:0] cmd_word_in,
    input  wire logic [1:0]  cmd_words_in,
    output logic             cmd_ready_out,
    output logic             rsp_valid_out,
    output logic [15:0]      rsp_word_out,
    output logic [15:0]      rsp_last_out
);
    typedef enum logic [2:0] {H_IDLE, H_LEAD, H_HIGH, H_LOW, H_LAG, H_GAP} dss_host_st_t;

    typedef struct packed {
        dss_host_st_t st;
        logic [7:0]   cnt;
        logic [3:0]   bit_idx;
        logic [1:0]   words_left;
        logic         first;
        dss_word_t    cmd;
        dss_word_t    tx;
        dss_word_t    rx;
        dss_word_t    first_rx;
        dss_word_t    last_rx;
        logic         wd;
        logic         sclk;
        logic         cs_n;
        logic         mosi;
        logic         rst_n;
        logic         rsp_valid;
        logic         ready;
    } dss_host_state_t;

    localparam dss_host_state_t HOST_RESET = '{st: H_IDLE, cs_n: CS_IDLE_LEVEL, default: '0};

    dss_host_state_t h;
    dss_host_state_t next_h;
    logic            miso_s;

    dss_sync #(
        .WIDTH (1)
    ) u_miso_sync (
        .ref_clk_in (ref_clk_in),
        .sys_rst_in (sys_rst_in),
        .clk_en_in  (clk_en_in),
        .async_in   (link.serial_out),
        .sync_out   (miso_s)
    );

    // =====================================================================
    // frame sequencer; the link clock comes from a divider of this clock
    always_comb begin
        dss_word_t w;
        w = '0;
        next_h           = h;
        next_h.rsp_valid = 1'b0;
        next_h.rst_n     = 1'b1;
        case (h.st)
            H_IDLE: begin
                next_h.ready = 1'b1;
                if (cmd_valid_in && h.ready) begin
                    w = {!h.wd, 1'b0, cmd_word_in};
                    w[PARITY_POS] = dss_odd_ones(w);
                    next_h.wd         = !h.wd;
                    next_h.cmd        = w;
                    next_h.tx         = w;
                    next_h.mosi       = w[WDOG_POS];
                    next_h.cs_n       = 1'b0;
                    next_h.ready      = 1'b0;
                    next_h.first      = 1'b1;
                    next_h.bit_idx    = 4'h0;
                    next_h.words_left = (cmd_words_in == 2'b00) ? 2'b00 : cmd_words_in - 2'b01;
                    next_h.cnt        = 8'(CS_LEAD_CYC - 1);
                    next_h.st         = H_LEAD;
                end
            end
            H_LEAD, H_LOW: begin
                if (h.cnt != 8'h00) begin
                    next_h.cnt = h.cnt - 8'h01;
                end else begin
                    next_h.sclk = 1'b1;
                    next_h.rx   = {h.rx[WORD_BITS-2:0], miso_s};
                    next_h.cnt  = 8'(SCLK_HALF_CYC - 1);
                    next_h.st   = H_HIGH;
                end
            end
            H_HIGH: begin
                if (h.cnt != 8'h00) begin
                    next_h.cnt = h.cnt - 8'h01;
                end else begin
                    next_h.sclk = 1'b0;
                    next_h.cnt  = 8'(SCLK_HALF_CYC - 1);
                    next_h.st   = H_LOW;
                    if (h.bit_idx != 4'hF) begin
                        next_h.bit_idx = h.bit_idx + 4'h1;
                        next_h.tx      = {h.tx[WORD_BITS-2:0], 1'b0};
                        next_h.mosi    = h.tx[WORD_BITS-2];
                    end else begin
                        next_h.first   = 1'b0;
                        next_h.bit_idx = 4'h0;
                        if (h.first) begin
                            next_h.first_rx = h.rx;
                        end
                        if (h.words_left == 2'b00) begin
                            next_h.last_rx = h.rx;
                            next_h.cnt     = 8'(CS_LAG_CYC - 1);
                            next_h.st      = H_LAG;
                        end else begin
                            // select stays low so the word travels down the chain
                            next_h.words_left = h.words_left - 2'b01;
                            next_h.tx         = h.cmd;
                            next_h.mosi       = h.cmd[WDOG_POS];
                        end
                    end
                end
            end
            H_LAG: begin
                if (h.cnt != 8'h00) begin
                    next_h.cnt = h.cnt - 8'h01;
                end else begin
                    next_h.cs_n      = 1'b1;
                    next_h.rsp_valid = 1'b1;
                    next_h.cnt       = 8'(CS_GAP_CYC - 1);
                    next_h.st        = H_GAP;
                end
            end
            default: begin
                if (h.cnt != 8'h00) begin
                    next_h.cnt = h.cnt - 8'h01;
                end else begin
                    next_h.ready = 1'b1;
                    next_h.st    = H_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            h <= HOST_RESET;
        end else if (clk_en_in) begin
            h <= next_h;
        end
    end

    // =====================================================================
    // pins and user side
    assign link.chip_select_n = h.cs_n;
    assign link.link_clk      = h.sclk;
    assign link.serial_in     = h.mosi;
    assign link.reset_input_n = h.rst_n;
    assign cmd_ready_out      = h.ready;
    assign rsp_valid_out      = h.rsp_valid;
    assign rsp_word_out       = h.first_rx;
    assign rsp_last_out       = h.last_rx;
endmodule : dss_host_end
`default_nettype wire

// *** design/dss_pkg.sv ***
// shared constants, types and helpers for the dual switch serial command port
package dss_pkg;
    // =====================================================================
    // word layout
    localparam int WORD_BITS  = 16;
    localparam int DATA_BITS  = 10;
    localparam int WDOG_POS   = 15;
    localparam int PARITY_POS = 14;
    localparam int BANK_POS   = 13;
    localparam int ADDR_MSB   = 12;
    localparam int ADDR_LSB   = 10;

    typedef logic [WORD_BITS-1:0] dss_word_t;
    typedef logic [DATA_BITS-1:0] dss_field_t;

    // =====================================================================
    // input register addresses (D12:D10)
    localparam logic [2:0] ADDR_STATUS_PTR = 3'h0;
    localparam logic [2:0] ADDR_DUTY       = 3'h1;
    localparam logic [2:0] ADDR_CHAN_CFG   = 3'h2;
    localparam logic [2:0] ADDR_OC_CFG     = 3'h4;
    localparam logic [2:0] ADDR_RETRY_CFG  = 3'h5;
    localparam logic [2:0] ADDR_GLOBAL_CFG = 3'h6;
    localparam logic [2:0] ADDR_CAL        = 3'h7;

    // output register select codes (pointer D2:D0)
    localparam logic [2:0] SEL_STATUS = 3'h0;
    localparam logic [2:0] SEL_FAULT  = 3'h1;
    localparam logic [2:0] SEL_DUTY   = 3'h2;
    localparam logic [2:0] SEL_CHAN   = 3'h3;
    localparam logic [2:0] SEL_OC     = 3'h4;
    localparam logic [2:0] SEL_RETRY  = 3'h5;
    localparam logic [2:0] SEL_GLOBAL = 3'h6;
    localparam logic [2:0] SEL_DIAG   = 3'h7;

    // writable field masks, fixed pattern and reset values
    localparam dss_field_t MASK_STATUS_PTR = 10'h007;
    localparam dss_field_t MASK_CFG        = 10'h1FF;
    localparam dss_field_t MASK_RETRY      = 10'h11F;
    localparam dss_field_t CAL_PATTERN     = 10'h15B;
    localparam dss_field_t FIELD_RESET     = 10'h000;
    localparam logic       CS_IDLE_LEVEL   = 1'b1;

    // =====================================================================
    // link timing of the command master
    localparam int REF_PERIOD_PS = 5000;
    localparam int SCLK_HALF_NS  = 15;
    localparam int CS_LEAD_NS    = 30;
    localparam int CS_LAG_NS     = 15;
    localparam int CS_GAP_NS     = 40;

    // least times: round up, never below one cycle
    function automatic int dss_ns_to_cyc(input int ns);
        int c;
        c = (ns * 1000 + REF_PERIOD_PS - 1) / REF_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction : dss_ns_to_cyc

    localparam int SCLK_HALF_CYC = dss_ns_to_cyc(SCLK_HALF_NS);
    localparam int CS_LEAD_CYC   = dss_ns_to_cyc(CS_LEAD_NS);
    localparam int CS_LAG_CYC    = dss_ns_to_cyc(CS_LAG_NS);
    localparam int CS_GAP_CYC    = dss_ns_to_cyc(CS_GAP_NS);

    // even parity over the whole word means this returns zero
    function automatic logic dss_odd_ones(input dss_word_t w);
        return ^w;
    endfunction : dss_odd_ones
endpackage : dss_pkg

// *** design/dss_spi_if.sv ***
// serial command link between the command master and the switch controller
`timescale 1ns/1ps
`default_nettype none
interface dss_spi_if;
    logic chip_select_n;
    logic link_clk;
    logic serial_in;
    logic serial_out;
    logic serial_out_oe_n;
    logic reset_input_n;

    modport dev (
        input  chip_select_n,
        input  link_clk,
        input  serial_in,
        input  reset_input_n,
        output serial_out,
        output serial_out_oe_n
    );

    modport host (
        output chip_select_n,
        output link_clk,
        output serial_in,
        output reset_input_n,
        input  serial_out,
        input  serial_out_oe_n
    );
endinterface : dss_spi_if
`default_nettype wire

// *** design/dss_sync.sv ***
// two flip-flop level synchroniser into the reference clock domain
`timescale 1ns/1ps
`default_nettype none
module dss_sync
    import dss_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input  wire logic             ref_clk_in,
    input  wire logic             sys_rst_in,
    input  wire logic             clk_en_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } dss_sync_state_t;

    dss_sync_state_t s;
    dss_sync_state_t next_s;

    // =====================================================================
    // meta stage feeds only the stable stage
    always_comb begin
        next_s        = s;
        next_s.meta   = async_in;
        next_s.stable = s.meta;
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            s <= '0;
        end else if (clk_en_in) begin
            s <= next_s;
        end
    end

    assign sync_out = s.stable;
endmodule : dss_sync
`default_nettype wire

// *** verif/dss_link_sva.sv ***
// link protocol checker for the serial command port
`timescale 1ns/1ps
`default_nettype none
module dss_link_sva (
    input  wire logic ref_clk_in,
    input  wire logic sys_rst_in,
    input  wire logic chip_select_n,
    input  wire logic link_clk,
    input  wire logic serial_in,
    input  wire logic serial_out,
    input  wire logic serial_out_oe_n,
    input  wire logic reset_input_n
);
    // =====================================================================
    // frame helper: bits seen at link clock rises
    logic        clk_q;
    logic [3:0]  bit_cnt;
    logic [15:0] shift_q;
    always_ff @(posedge ref_clk_in) begin
        clk_q <= link_clk;
        if (chip_select_n) begin
            bit_cnt <= 4'h0;
        end else if (link_clk && !clk_q) begin
            bit_cnt <= bit_cnt + 4'h1;
            shift_q <= {shift_q[14:0], serial_in};
        end
    end
    // =====================================================================
    // assertions
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (sys_rst_in);
    sequence s_frame_start;
        $fell(chip_select_n);
    endsequence
    sequence s_clk_quiet;
        !link_clk [*3];
    endsequence
    chk_oe_tracks_cs: assert property (serial_out_oe_n == chip_select_n)
        else $error("output enable does not follow chip select");
    chk_clk_lead: assert property (s_frame_start |-> s_clk_quiet)
        else $error("link clock rose too soon after select");
    chk_clk_idle: assert property (chip_select_n && $past(chip_select_n) |-> !link_clk)
        else $error("link clock active between frames");
    chk_si_hold: assert property (link_clk && $past(link_clk) |-> $stable(serial_in))
        else $error("serial input moved while link clock high");
    chk_so_hold: assert property (!chip_select_n && !link_clk && !$past(chip_select_n) && !$past(link_clk)
        |-> $stable(serial_out))
        else $error("serial output moved while link clock low");
    chk_no_xfer_rst: assert property (!reset_input_n |-> chip_select_n && !link_clk)
        else $error("transfer while device reset held");
    chk_whole_words: assert property ($rose(chip_select_n) |-> bit_cnt == 4'h0)
        else $error("frame not a whole number of words");
    chk_even_parity: assert property ($rose(chip_select_n) |-> !(^shift_q))
        else $error("last word has odd parity");
endmodule : dss_link_sva
`default_nettype wire

// *** verif/tb.sv ***
// testbench: host end drives the device end across the serial link
`timescale 1ns/1ps
`default_nettype none
module tb
    import dss_pkg::*;
;
    logic                 clk = 1'b0;
    logic                 rst = 1'b1;
    logic                 en = 1'b1;
    logic                 cv = 1'b0;
    logic [13:0]          cw = 14'h0000;
    logic [1:0]           cn = 2'h1;
    logic                 hot = 1'b0;
    logic [1:0]           on = 2'h2;
    logic [6:0]           misc = 7'h5A;
    logic                 nm = 1'b1;
    logic                 lp;
    logic                 rv;
    logic                 rdy;
    logic                 flag;
    logic [15:0]          rw;
    logic [15:0]          rl;
    logic [1:0][7:0][9:0] regs;
    int                   err_total = 0;
    int                   comparisons = 0;
    int                   cyc = 0;
    int                   lp_cnt = 0;
    int                   rv_cnt = 0;
    dss_spi_if link();
    dss_host_end i_dss_host_end (.ref_clk_in(clk), .sys_rst_in(rst), .clk_en_in(en), .link(link),
        .cmd_valid_in(cv), .cmd_word_in(cw), .cmd_words_in(cn), .cmd_ready_out(rdy), .rsp_valid_out(rv),
        .rsp_word_out(rw), .rsp_last_out(rl));
    dss_dev_end i_dss_dev_end (.ref_clk_in(clk), .sys_rst_in(rst), .clk_en_in(en), .link(link),
        .ch_on_in(on), .temp_high_in(hot), .normal_mode_in(nm), .status_misc_in(misc),
        .fault_bits_in(12'hA95), .diag_in(9'h000), .input_regs_out(regs), .latch_pulse_out(lp),
        .temp_prewarning_flag_out(flag));
    dss_link_sva i_dss_link_sva (.ref_clk_in(clk), .sys_rst_in(rst), .chip_select_n(link.chip_select_n),
        .link_clk(link.link_clk), .serial_in(link.serial_in), .serial_out(link.serial_out),
        .serial_out_oe_n(link.serial_out_oe_n), .reset_input_n(link.reset_input_n));
    initial begin
        forever #2.5 clk = ~clk;
    end
    // =====================================================================
    // tasks
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // one command frame of n words; returns once the host is ready again
    task automatic cmd(input logic [13:0] w, input logic [1:0] n);
        int t;
        cv <= 1'b1;
        cw <= w;
        cn <= n;
        @(posedge clk);
        cv <= 1'b0;
        repeat (2) @(posedge clk);
        for (t = 0; t < 400 && rdy !== 1'b1; t++) @(posedge clk);
        chk("cmd_done", {15'h0000, rdy}, 16'h0001);
    endtask : cmd
    task automatic close_out();
        if (err_total == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (lp === 1'b1) lp_cnt <= lp_cnt + 1;
        if (rv === 1'b1) rv_cnt <= rv_cnt + 1;
        if (cyc == 4000) begin
            err_total++;
            close_out();
        end
    end
    // =====================================================================
    // scenarios
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        chk("regs_reset", {15'h0000, |regs}, 16'h0000);
        cmd({1'b0, ADDR_DUTY, 10'h2AB}, 2'h1);
        chk("duty0", {6'h00, regs[0][1]}, 16'h00AB);
        cmd({1'b1, ADDR_CHAN_CFG, 10'h3FF}, 2'h1);
        chk("chan1", {6'h00, regs[1][2]}, 16'h01FF);
        chk("chan0", {6'h00, regs[0][2]}, 16'h0000);
        cmd({1'b1, ADDR_GLOBAL_CFG, 10'h3C5}, 2'h1);
        chk("global", {6'h00, regs[0][6]}, 16'h01C5);
        cmd({1'b0, ADDR_RETRY_CFG, 10'h3FF}, 2'h1);
        chk("retry", {6'h00, regs[0][5]}, 16'h011F);
        cmd({1'b0, ADDR_CAL, 10'h15A}, 2'h1);
        chk("cal_bad", {6'h00, regs[0][7]}, 16'h0000);
        cmd({1'b0, ADDR_CAL, CAL_PATTERN}, 2'h1);
        chk("cal_ok", {6'h00, regs[0][7]}, 16'h015B);
        cmd({1'b0, ADDR_STATUS_PTR, 7'h7F, SEL_STATUS}, 2'h1);
        cmd({1'b0, ADDR_DUTY, 10'h0F0}, 2'h2);
        // seventh command sent a high toggle bit and clean parity
        chk("status", rw, {2'h2, 1'b0, SEL_STATUS, 1'b1, misc, on});
        // eighth command: toggle bit low, five payload ones need the parity bit
        chk("echo", rl, {2'h1, 1'b0, ADDR_DUTY, 10'h0F0});
        nm <= 1'b0;
        hot <= 1'b1;
        repeat (10) @(posedge clk);
        chk("flag_off", {15'h0000, flag}, 16'h0000);
        nm <= 1'b1;
        repeat (10) @(posedge clk);
        chk("flag_set", {15'h0000, flag}, 16'h0001);
        hot <= 1'b0;
        cmd({1'b0, ADDR_STATUS_PTR, 7'h00, SEL_FAULT}, 2'h1);
        chk("flag_held", {15'h0000, flag}, 16'h0001);
        cmd({1'b0, ADDR_STATUS_PTR, 7'h00, SEL_FAULT}, 2'h1);
        chk("fault", rw, {2'h2, 1'b0, SEL_FAULT, 1'b1, 3'h4, 6'h15});
        chk("flag_clr", {15'h0000, flag}, 16'h0000);
        chk("latches", lp_cnt[15:0], 16'h0009);
        chk("responses", rv_cnt[15:0], 16'h000A);
        close_out();
    end
endmodule : tb
`default_nettype wire
